// ### design/rct_pkg.sv
// package for the reload/capture timer: register map, field positions, types
// assumes a plain register port with 32-bit data and byte addresses
package rct_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_RELOAD = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h10;
	localparam logic [7:0] OFF_CLEAR = 8'h18;
	localparam logic [7:0] OFF_IRQ_EN = 8'h1c;
	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int CTL_CAP_RL = 0;
	localparam int CTL_CT = 1;
	localparam int CTL_RUN = 2;
	localparam int CTL_EXEN = 3;
	localparam int CTL_EXF = 6;
	localparam int CTL_OVF = 7;
	localparam int CTL_INSEL_LO = 8;
	localparam int CTL_TRSEL_LO = 10;
	// ----------------------------------------
	// mode fields
	// ----------------------------------------
	localparam int MOD_UPDN = 0;
	localparam int MOD_PRE_LO = 1;
	localparam int MOD_PRESCALER_ENABLE = 4;
	localparam int MOD_EDGE = 5;
	localparam int MOD_XSTART = 6;
	localparam int MOD_XEDGE = 7;
	// ----------------------------------------
	// clear and enable fields
	// ----------------------------------------
	localparam int CLR_EXF = 6;
	localparam int CLR_OVF = 7;
	localparam int IEN_EXF = 0;
	localparam int IEN_OVF = 1;
	// ----------------------------------------
	// values and counts
	// ----------------------------------------
	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
	localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [6:0] PRE_ONE = 7'h01;
	localparam logic [3:0] FIX_DIV12_LAST = 4'hb;
	localparam logic [3:0] FIX_DIV_ZERO = 4'h0;
	localparam logic [3:0] FIX_DIV_ONE = 4'h1;
	typedef struct packed {
		logic [3:0] count_src;
		logic [3:0] trig_src;
	} rct_pins_s;
endpackage

// ### design/rct_timer.sv
// reload/capture timer with 16-bit counter, prescaler, input muxes, flags
// assumes synchronous inputs and a master that never waits for the slave
// How it works
// - select 0 reloads counter from reload value on overflow or enabled trigger edge
// - select 1 with events enabled captures counter on the trigger edge
// - timer select picks internal clock or falling edges of count input
// - run bit 2 stops counter at 0, lets it count at 1
// - external enable bit 3 gates trigger edges for reload, capture and flag; 0 ignores them, external start does not
// - external flag bit 6 sets on enabled trigger edge, sticky
// - overflow flag bit 7 sets on overflow or underflow, sticky
// - count select field picks one of four count sources
// - trigger select field picks one of four trigger sources
// - up/down enable lets trigger level set direction, else up only
// - prescaler field divides clock by two to the power of code
// - prescaler enable off uses fixed divider, on uses prescaler
// - edge select picks falling (0) or rising (1) trigger edge
// - external start sets run bit on edge chosen by start edge bit
// - software writes to reload value beat hardware capture
// - counter is software accessible, write wins, advances only when running
// - writing 1 to clear bits 6 or 7 clears the matching flag
// - interrupt enable holds external enable bit 0, overflow enable bit 1
// - reserved bits read as zero
// - external count samples each clock, counts on high then low
// - down count underflows at reload value, flags and reloads all ones
// - capture mode counts up, overflow flags and reloads zero
// - capture in an increment cycle stores the incremented value
module rct_timer (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// external inputs
	input wire rct_pkg::rct_pins_s pins,
	// fixed divider choice: 1 selects divide by 2, 0 divide by 12
	input wire logic fix_div2_sel,
	// status
	output logic irq_reg,
	output logic [15:0] count_out_reg
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic cap_rl_reg;
	logic ct_reg;
	logic run_reg;
	logic exen_reg;
	logic exf_reg;
	logic ovf_reg;
	logic [1:0] insel_reg;
	logic [1:0] trsel_reg;
	logic updn_reg;
	logic [2:0] pre_reg;
	logic prescaler_enable_reg;
	logic edge_reg;
	logic xstart_reg;
	logic xedge_reg;
	logic [15:0] rc_reg;
	logic [15:0] cnt_reg;
	logic [1:0] ien_reg;
	logic cin_prev_reg;
	logic tin_prev_reg;
	logic [6:0] pre_cnt_reg;
	logic [3:0] fix_cnt_reg;

	function automatic logic pick(input logic [3:0] src, input logic [1:0] sel);
		pick = src[sel];
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic wr);
		hit = wr && (a == off);
	endfunction

	// ----------------------------------------
	// input selection and edges
	// ----------------------------------------
	logic cin;
	logic tin;
	logic cin_fall;
	logic tin_rise;
	logic tin_fall;
	logic trig_edge;
	logic start_edge;
	logic ext_ev;
	assign cin = pick(pins.count_src, insel_reg);
	assign tin = pick(pins.trig_src, trsel_reg);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cin_prev_reg <= 1'b0;
			tin_prev_reg <= 1'b0;
		end else begin
			cin_prev_reg <= cin;
			tin_prev_reg <= tin;
		end
	end

	assign cin_fall = cin_prev_reg && !cin;
	assign tin_rise = !tin_prev_reg && tin;
	assign tin_fall = tin_prev_reg && !tin;
	assign trig_edge = edge_reg ? tin_rise : tin_fall;
	assign start_edge = xedge_reg ? tin_rise : tin_fall;
	assign ext_ev = exen_reg && trig_edge;

	// ----------------------------------------
	// count clock
	// ----------------------------------------
	logic pre_tick;
	logic fix_tick;
	logic int_tick;
	logic tick;
	logic [6:0] pre_last;
	logic [3:0] fix_last;
	localparam logic [6:0] PRE_ONE_W = rct_pkg::PRE_ONE;
	assign pre_last = 7'((PRE_ONE_W << pre_reg) - PRE_ONE_W);
	assign pre_tick = (pre_cnt_reg >= pre_last);
	assign fix_last = fix_div2_sel ? rct_pkg::FIX_DIV_ONE : rct_pkg::FIX_DIV12_LAST;
	assign fix_tick = (fix_cnt_reg >= fix_last);
	assign int_tick = prescaler_enable_reg ? pre_tick : fix_tick;
	assign tick = run_reg && (ct_reg ? cin_fall : int_tick);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_reg <= '0;
		end else if (pre_tick) begin
			pre_cnt_reg <= '0;
		end else begin
			pre_cnt_reg <= 7'(pre_cnt_reg + PRE_ONE_W);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fix_cnt_reg <= rct_pkg::FIX_DIV_ZERO;
		end else if (fix_tick) begin
			fix_cnt_reg <= rct_pkg::FIX_DIV_ZERO;
		end else begin
			fix_cnt_reg <= 4'(fix_cnt_reg + rct_pkg::FIX_DIV_ONE);
		end
	end

	// ----------------------------------------
	// counter next value
	// ----------------------------------------
	logic down;
	logic ovf_ev;
	logic unf_ev;
	logic [15:0] cnt_next;
	logic do_capture;
	assign down = updn_reg && !tin && !cap_rl_reg;
	assign ovf_ev = tick && !down && (cnt_reg == rct_pkg::CNT_ALL_ONES);
	assign unf_ev = tick && down && (cnt_reg == rc_reg);
	assign do_capture = cap_rl_reg && ext_ev;

	always_comb begin
		cnt_next = cnt_reg;
		if (unf_ev) begin
			cnt_next = rct_pkg::CNT_ALL_ONES;
		end else if (ovf_ev) begin
			cnt_next = cap_rl_reg ? rct_pkg::CNT_ZERO : rc_reg;
		end else if (tick) begin
			cnt_next = down ? 16'(cnt_reg - rct_pkg::CNT_ONE) : 16'(cnt_reg + rct_pkg::CNT_ONE);
		end
		if (!cap_rl_reg && ext_ev) begin
			cnt_next = rc_reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= rct_pkg::RESET_VALUE[15:0];
		end else if (hit(reg_addr, rct_pkg::OFF_COUNT, reg_write)) begin
			cnt_reg <= reg_wdata[15:0];
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rc_reg <= rct_pkg::RESET_VALUE[15:0];
		end else if (hit(reg_addr, rct_pkg::OFF_RELOAD, reg_write)) begin
			rc_reg <= reg_wdata[15:0];
		end else if (do_capture) begin
			rc_reg <= cnt_next;
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	logic wr_ctl;
	assign wr_ctl = hit(reg_addr, rct_pkg::OFF_CONTROL, reg_write);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cap_rl_reg <= 1'b0;
			ct_reg <= 1'b0;
			exen_reg <= 1'b0;
			insel_reg <= 2'h0;
			trsel_reg <= 2'h0;
		end else if (wr_ctl) begin
			cap_rl_reg <= reg_wdata[rct_pkg::CTL_CAP_RL];
			ct_reg <= reg_wdata[rct_pkg::CTL_CT];
			exen_reg <= reg_wdata[rct_pkg::CTL_EXEN];
			insel_reg <= reg_wdata[rct_pkg::CTL_INSEL_LO +: 2];
			trsel_reg <= reg_wdata[rct_pkg::CTL_TRSEL_LO +: 2];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			run_reg <= 1'b0;
		end else if (xstart_reg && start_edge) begin
			run_reg <= 1'b1;
		end else if (wr_ctl) begin
			run_reg <= reg_wdata[rct_pkg::CTL_RUN];
		end
	end

	// ----------------------------------------
	// sticky flags, set wins over clear
	// ----------------------------------------
	logic wr_clr;
	assign wr_clr = hit(reg_addr, rct_pkg::OFF_CLEAR, reg_write);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			exf_reg <= 1'b0;
		end else if (ext_ev) begin
			exf_reg <= 1'b1;
		end else if (wr_clr && reg_wdata[rct_pkg::CLR_EXF]) begin
			exf_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ovf_reg <= 1'b0;
		end else if (ovf_ev || unf_ev) begin
			ovf_reg <= 1'b1;
		end else if (wr_clr && reg_wdata[rct_pkg::CLR_OVF]) begin
			ovf_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// mode and enable registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			updn_reg <= 1'b0;
			pre_reg <= 3'h0;
			prescaler_enable_reg <= 1'b0;
			edge_reg <= 1'b0;
			xstart_reg <= 1'b0;
			xedge_reg <= 1'b0;
		end else if (hit(reg_addr, rct_pkg::OFF_MODE, reg_write)) begin
			updn_reg <= reg_wdata[rct_pkg::MOD_UPDN];
			pre_reg <= reg_wdata[rct_pkg::MOD_PRE_LO +: 3];
			prescaler_enable_reg <= reg_wdata[rct_pkg::MOD_PRESCALER_ENABLE];
			edge_reg <= reg_wdata[rct_pkg::MOD_EDGE];
			xstart_reg <= reg_wdata[rct_pkg::MOD_XSTART];
			xedge_reg <= reg_wdata[rct_pkg::MOD_XEDGE];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ien_reg <= 2'h0;
		end else if (hit(reg_addr, rct_pkg::OFF_IRQ_EN, reg_write)) begin
			ien_reg <= reg_wdata[1:0];
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
			count_out_reg <= 16'h0000;
		end else begin
			irq_reg <= (exf_reg && ien_reg[rct_pkg::IEN_EXF]) ||
				(ovf_reg && ien_reg[rct_pkg::IEN_OVF]);
			count_out_reg <= cnt_reg;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	logic [31:0] rd_next;
	always_comb begin
		rd_next = 32'h0000_0000;
		unique case (reg_addr)
			rct_pkg::OFF_CONTROL: begin
				rd_next[rct_pkg::CTL_CAP_RL] = cap_rl_reg;
				rd_next[rct_pkg::CTL_CT] = ct_reg;
				rd_next[rct_pkg::CTL_RUN] = run_reg;
				rd_next[rct_pkg::CTL_EXEN] = exen_reg;
				rd_next[rct_pkg::CTL_EXF] = exf_reg;
				rd_next[rct_pkg::CTL_OVF] = ovf_reg;
				rd_next[rct_pkg::CTL_INSEL_LO +: 2] = insel_reg;
				rd_next[rct_pkg::CTL_TRSEL_LO +: 2] = trsel_reg;
			end
			rct_pkg::OFF_MODE: begin
				rd_next[rct_pkg::MOD_UPDN] = updn_reg;
				rd_next[rct_pkg::MOD_PRE_LO +: 3] = pre_reg;
				rd_next[rct_pkg::MOD_PRESCALER_ENABLE] = prescaler_enable_reg;
				rd_next[rct_pkg::MOD_EDGE] = edge_reg;
				rd_next[rct_pkg::MOD_XSTART] = xstart_reg;
				rd_next[rct_pkg::MOD_XEDGE] = xedge_reg;
			end
			rct_pkg::OFF_RELOAD: rd_next[15:0] = rc_reg;
			rct_pkg::OFF_COUNT: rd_next[15:0] = cnt_reg;
			rct_pkg::OFF_IRQ_EN: rd_next[1:0] = ien_reg;
			default: rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_read) begin
			reg_rdata <= rd_next;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

// ### verif/rct_timer_props.sv
// checker for the timer register port and status outputs
// assumes it is bound to rct_timer
module rct_timer_props (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	// status
	input wire logic irq_reg,
	input wire logic [15:0] count_out_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_rdata_after_read: assert property (reg_rdata != 32'h0 |-> $past(reg_read))
		else $error("read data without read");
	a_clear_reads_zero: assert property (reg_read && reg_addr == rct_pkg::OFF_CLEAR |=>
		reg_rdata == 32'h0) else $error("clear register read not zero");
	a_ctrl_reserved: assert property (reg_read && reg_addr == rct_pkg::OFF_CONTROL |=>
		reg_rdata[31:12] == 20'h0 && reg_rdata[5:4] == 2'h0) else $error("control reserved set");
	a_mode_reserved: assert property (reg_read && reg_addr == rct_pkg::OFF_MODE |=>
		reg_rdata[31:8] == 24'h0) else $error("mode reserved set");
	a_value_upper_zero: assert property (reg_read && (reg_addr == rct_pkg::OFF_RELOAD ||
		reg_addr == rct_pkg::OFF_COUNT) |=> reg_rdata[31:16] == 16'h0) else $error("upper half set");
	a_ien_readback: assert property (reg_write && reg_addr == rct_pkg::OFF_IRQ_EN ##1
		reg_read && reg_addr == rct_pkg::OFF_IRQ_EN |=> reg_rdata == {30'h0, $past(reg_wdata[1:0], 2)})
		else $error("enable readback wrong");
	a_count_write_wins: assert property (reg_write && reg_addr == rct_pkg::OFF_COUNT |=>
		##1 count_out_reg == $past(reg_wdata[15:0], 2)) else $error("count write lost");
	a_irq_masked: assert property (reg_write && reg_addr == rct_pkg::OFF_IRQ_EN &&
		reg_wdata[1:0] == 2'h0 |=> ##1 !irq_reg) else $error("irq while masked");
endmodule
bind rct_timer rct_timer_props rct_timer_props_inst (.mclk, .rst_n, .reg_addr, .reg_wdata,
	.reg_write, .reg_read, .reg_rdata, .irq_reg, .count_out_reg);

// ### verif/rct_pin_model.sv
// count and trigger sources in front of the timer
// assumes the bench sets levels just after a rising edge
module rct_pin_model (
	// clock
	input wire logic mclk,
	// wanted routes and levels
	input wire logic [1:0] count_sel,
	input wire logic [1:0] trig_sel,
	input wire logic count_lvl,
	input wire logic trig_lvl,
	// pins into the timer
	output rct_pkg::rct_pins_s pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic noise_reg = 1'b0;
	always @(posedge mclk) noise_reg <= !noise_reg;
	// unused sources toggle so a wrong route shows up
	always_comb begin
		pins.count_src = {4{noise_reg}};
		pins.trig_src = {4{noise_reg}};
		pins.count_src[count_sel] = count_lvl;
		pins.trig_src[trig_sel] = trig_lvl;
	end
endmodule

// ### verif/tb_rct_timer.sv
// self-checking bench for the reload/capture timer
// assumes the package, timer and pin model come first
module tb_rct_timer;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic fix_div2_sel = 1'b1;
	logic [31:0] reg_rdata;
	logic irq_reg;
	logic [15:0] count_out_reg;
	logic [1:0] csel = 2'h0;
	logic [1:0] tsel = 2'h0;
	logic clvl = 1'b1;
	logic tlvl = 1'b1;
	logic pend = 1'b0;
	logic [31:0] rnd;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int num_errors = 0;
	int n_compared = 0;
	int seed = 32'h2a46;
	rct_pkg::rct_pins_s pins;
	rct_timer rct_timer_inst (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .pins, .fix_div2_sel, .irq_reg, .count_out_reg);
	rct_pin_model rct_pin_model_inst (.mclk, .count_sel(csel), .trig_sel(tsel),
		.count_lvl(clvl), .trig_lvl(tlvl), .pins);
	initial forever #2 mclk = ~mclk;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		reg_write <= w;
		reg_read <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic idle(input int n);
		reg_write <= 1'b0;
		reg_read <= 1'b0;
		repeat (n) @(posedge mclk);
	endtask
	function automatic logic [31:0] ctl(input logic [3:0] f, input logic [1:0] i, input logic [1:0] t);
		return {20'h0, t, i, 4'h0, f};
	endfunction
	task automatic measure(input logic [31:0] md, input int w, input logic [15:0] e);
		wr(rct_pkg::OFF_MODE, md);
		wr(rct_pkg::OFF_CONTROL, ctl(4'h4, 2'h0, 2'h0));
		wr(rct_pkg::OFF_COUNT, 32'h0);
		idle(w - 1);
		wr(rct_pkg::OFF_CONTROL, ctl(4'h0, 2'h0, 2'h0));
		rd(rct_pkg::OFF_COUNT, '1, {16'h0, e});
		idle(1);
		chk("count_out", {16'h0, count_out_reg}, {16'h0, e});
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// read data checker
	always @(posedge mclk) begin
		if (pend)
			chk("rdata", reg_rdata & msk_q.pop_front(), exp_q.pop_front());
		pend = reg_read;
	end
	initial begin
		#50us;
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		for (int k = 0; k < 9; k++)
			rd(8'(k * 4), '1, 32'h0);
		for (int k = 0; k < 4; k++) begin
			rnd = $random(seed);
			wr(rct_pkg::OFF_MODE, rnd);
			wr(rct_pkg::OFF_RELOAD, rnd);
			wr(8'h24, rnd);
			wr(rct_pkg::OFF_IRQ_EN, rnd);
			rd(rct_pkg::OFF_IRQ_EN, '1, rnd & 32'h3);
			rd(rct_pkg::OFF_MODE, '1, rnd & 32'hff);
			rd(rct_pkg::OFF_RELOAD, '1, rnd & 32'hffff);
			rd(8'h24, '1, 32'h0);
		end
		$display("registers done");
		for (int p = 0; p < 8; p++)
			measure(32'h10 | (p << 1), 256, 16'(256 >> p));
		measure(32'h0, 264, 16'd132);
		fix_div2_sel <= 1'b0;
		measure(32'h0, 264, 16'd22);
		$display("prescaler done");
		for (int s = 0; s < 4; s++) begin
			csel <= 2'(s);
			wr(rct_pkg::OFF_CONTROL, ctl(4'h6, 2'(s), 2'h0));
			wr(rct_pkg::OFF_COUNT, 32'h0);
			repeat (s + 3) begin
				clvl <= 1'b0;
				idle(2);
				clvl <= 1'b1;
				idle(2);
			end
			rd(rct_pkg::OFF_COUNT, '1, 32'(s + 3));
		end
		$display("external count done");
		wr(rct_pkg::OFF_IRQ_EN, 32'h1);
		for (int s = 0; s < 4; s++) begin
			tsel <= 2'(s);
			tlvl <= !s[0];
			wr(rct_pkg::OFF_MODE, 32'h10 | (s[0] << 5));
			wr(rct_pkg::OFF_CONTROL, ctl(4'h5, 2'h0, 2'(s)));
			wr(rct_pkg::OFF_CONTROL, ctl(4'hd, 2'h0, 2'(s)));
			wr(rct_pkg::OFF_COUNT, 32'h0);
			idle(9);
			tlvl <= s[0];
			idle(4);
			rd(rct_pkg::OFF_RELOAD, '1, 32'd10);
			rd(rct_pkg::OFF_CONTROL, 32'hc0, 32'h40);
			chk("irq", {31'h0, irq_reg}, 32'h1);
			wr(rct_pkg::OFF_CLEAR, 32'h40);
			rd(rct_pkg::OFF_CONTROL, 32'h40, 32'h0);
		end
		wr(rct_pkg::OFF_CONTROL, ctl(4'h5, 2'h0, 2'h3));
		tlvl <= 1'b0;
		idle(2);
		tlvl <= 1'b1;
		idle(2);
		rd(rct_pkg::OFF_RELOAD, '1, 32'd10);
		rd(rct_pkg::OFF_CONTROL, 32'h40, 32'h0);
		wr(rct_pkg::OFF_COUNT, 32'hfffe);
		idle(1);
		wr(rct_pkg::OFF_CONTROL, ctl(4'h1, 2'h0, 2'h3));
		rd(rct_pkg::OFF_COUNT, '1, 32'h0);
		rd(rct_pkg::OFF_CONTROL, 32'h80, 32'h80);
		wr(rct_pkg::OFF_CLEAR, 32'h80);
		$display("capture done");
		tsel <= 2'h0;
		wr(rct_pkg::OFF_MODE, 32'h10);
		wr(rct_pkg::OFF_RELOAD, 32'h1234);
		wr(rct_pkg::OFF_CONTROL, ctl(4'h4, 2'h0, 2'h0));
		wr(rct_pkg::OFF_COUNT, 32'hfffe);
		idle(3);
		wr(rct_pkg::OFF_CONTROL, ctl(4'h0, 2'h0, 2'h0));
		rd(rct_pkg::OFF_COUNT, '1, 32'h1236);
		wr(rct_pkg::OFF_IRQ_EN, 32'h2);
		wr(rct_pkg::OFF_CLEAR, 32'h0);
		rd(rct_pkg::OFF_CONTROL, 32'h80, 32'h80);
		chk("irq", {31'h0, irq_reg}, 32'h1);
		wr(rct_pkg::OFF_IRQ_EN, 32'h0);
		idle(2);
		chk("irq", {31'h0, irq_reg}, 32'h0);
		wr(rct_pkg::OFF_CLEAR, 32'h80);
		rd(rct_pkg::OFF_CONTROL, 32'h80, 32'h0);
		$display("overflow done");
		tlvl <= 1'b0;
		wr(rct_pkg::OFF_MODE, 32'h11);
		wr(rct_pkg::OFF_RELOAD, 32'hff00);
		wr(rct_pkg::OFF_COUNT, 32'hff03);
		wr(rct_pkg::OFF_CONTROL, ctl(4'h4, 2'h0, 2'h0));
		idle(6);
		wr(rct_pkg::OFF_CONTROL, ctl(4'h0, 2'h0, 2'h0));
		rd(rct_pkg::OFF_COUNT, 32'hfff0, 32'hfff0);
		rd(rct_pkg::OFF_CONTROL, 32'h80, 32'h80);
		$display("underflow done");
		wr(rct_pkg::OFF_MODE, 32'hd0);
		tlvl <= 1'b1;
		idle(3);
		rd(rct_pkg::OFF_CONTROL, 32'h4, 32'h4);
		idle(3);
		$display("external start done");
		end_sim();
	end
endmodule
